// file: dv/apb_master_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// core side bus master; read data is judged by the bench monitor
// ----------------------------------------------------------------
module apb_master_model (
    input  wire logic        clk_sys,
    input  wire logic        pready,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // entered just after a rising edge; leaves one edge after release
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~wd; // stale data must not look valid
        @(posedge clk_sys);
    endtask
endmodule // apb_master_model

// file: dv/extended_memory_op_unit_bench.sv
`timescale 1ns/1ns
`include "xmem_op_map.vh"
module extended_memory_op_unit_bench;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr, busy, skip_next, op_done;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [32:0] exp_q[$];
    int          miscompares = 0;
    int          tests_run = 0;
    always #2 clk_sys = ~clk_sys;

    extended_memory_op_unit i_extended_memory_op_unit (.clk_sys, .sys_rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .busy, .skip_next, .op_done);
    apb_master_model i_apb_master_model (.clk_sys, .pready, .psel, .penable, .pwrite,
        .paddr, .pwdata);

    // ----------------------------------------------------------------
    // reference results, written apart from the design's arithmetic
    // ----------------------------------------------------------------
    function automatic void model(input logic [4:0] op, input logic [2:0] b,
            inout logic [7:0] m, inout logic [7:0] w, inout logic [5:0] f, output logic sk);
        logic [8:0] d;
        logic [4:0] h;
        logic [7:0] r;
        logic       s, bi, v;
        sk = 1'b0;
        s = (op == `OP_SBB_REG || op == `OP_SBB_MEM);
        bi = s ? ~f[0] : 1'b0;
        d = {1'b0, w} - {1'b0, m} - bi;
        h = {1'b0, w[3:0]} - {1'b0, m[3:0]} - bi;
        r = d[7:0];
        v = (w[7] ^ m[7]) & (w[7] ^ r[7]);
        case (op)
            `OP_ROR_MEM: m = {m[0], m[7:1]};
            `OP_ROR_REG: w = {m[0], m[7:1]};
            `OP_RRB_MEM, `OP_RRB_REG: begin
                r = {f[0], m[7:1]};
                f[0] = m[0];
                if (op == `OP_RRB_MEM) m = r; else w = r;
            end
            `OP_SBB_REG, `OP_SBB_MEM, `OP_SUB_REG, `OP_SUB_MEM: begin
                f = {(r == 8'h00) & (s ? f[5] : 1'b1), v ^ r[7], v, h[4], r == 8'h00, ~d[8]};
                if (op[0]) m = r; else w = r;
            end
            `OP_DSK_MEM: begin m = m - 8'h01; sk = (m == 8'h00); end
            `OP_DSK_REG: begin w = m - 8'h01; sk = (w == 8'h00); end
            `OP_ISK_MEM: begin m = m + 8'h01; sk = (m == 8'h00); end
            `OP_ISK_REG: begin w = m + 8'h01; sk = (w == 8'h00); end
            `OP_FILL: m = 8'hff;
            `OP_SETBIT: m[b] = 1'b1;
            `OP_SKIP_BIT: sk = m[b];
            `OP_SKIP_NZ: sk = (m != 8'h00);
            `OP_SWAP_MEM: m = {m[3:0], m[7:4]};
            `OP_SWAP_REG: w = {m[3:0], m[7:4]};
            default: ;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // driver tasks and the read monitor
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_apb_master_model.xfer(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic e, input logic [31:0] d);
        exp_q.push_back({e, d});
        i_apb_master_model.xfer(1'b0, a, 32'h0);
    endtask
    // reads compared at the ready edge, where prdata is valid
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            tests_run++;
            if (exp_q.size() == 0 || {pslverr, prdata} !== exp_q.pop_front()) begin
                miscompares++;
                $display("FAIL %0t read of %h mismatched", $time, paddr);
            end
        end
    end

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // each pass is some 40 cycles; far more than the run needs
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        $display("FAIL %0t watchdog expired", $time);
        report_and_stop;
    end

    initial begin
        logic [7:0] m, w;
        logic [9:0] a;
        logic [5:0] f;
        logic [4:0] op;
        logic [2:0] b;
        logic       sk;
        int         k;
        k = $urandom(32'h5522bddb);
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        rd_chk(`OFF_WORK, 1'b0, 32'h0);
        rd_chk(`OFF_FLAGS, 1'b0, 32'h0);
        rd_chk(8'h18, 1'b1, 32'h0);
        rd_chk(8'h06, 1'b1, 32'h0);
        // every opcode three times, operand biased to the wrap edges
        for (int i = 0; i < 54; i++) begin
            op = 5'(i % 18);
            b = 3'($urandom);
            a = 10'($urandom);
            f = 6'($urandom);
            w = 8'($urandom);
            case ($urandom % 4)
                0: m = 8'h00;
                1: m = 8'h01;
                2: m = 8'hff;
                default: m = 8'($urandom);
            endcase
            wr(`OFF_ADDR, {22'h0, a});
            wr(`OFF_MDATA, {24'h0, m});
            wr(`OFF_WORK, {24'h0, w});
            wr(`OFF_FLAGS, {26'h0, f});
            wr(`OFF_CTRL, {21'h0, b, 3'h0, op});
            for (k = 0; k < 8 && op_done !== 1'b1; k++) @(posedge clk_sys);
            if (k == 8) begin
                miscompares++;
                $display("FAIL %0t operation never finished", $time);
            end
            @(posedge clk_sys);
            model(op, b, m, w, f, sk);
            rd_chk(`OFF_MDATA, 1'b0, {24'h0, m});
            rd_chk(`OFF_WORK, 1'b0, {24'h0, w});
            rd_chk(`OFF_FLAGS, 1'b0, {26'h0, f});
            rd_chk(`OFF_STAT, 1'b0, {30'h0, sk, 1'b0});
            $display("test %0d opcode %h done", i, op);
        end
        report_and_stop;
    end
endmodule // extended_memory_op_unit_bench
bind extended_memory_op_unit xmem_unit_chk i_xmem_unit_chk (.clk_sys, .sys_rst, .psel,
    .penable, .pwrite, .paddr, .pready, .pslverr, .busy, .skip_next, .op_done);

// file: dv/xmem_unit_chk.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// port checker: bus answer timing and operation framing
// ----------------------------------------------------------------
module xmem_unit_chk (
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       busy,
    input wire logic       skip_next,
    input wire logic       op_done
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // one wait state, then a single ready pulse
    property p_rdy_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("ready late");
    property p_rdy_pulse;
        pready |-> $past(psel && penable) ##1 !pready;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready not a pulse");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    // holes and misaligned words are refused
    property p_unmapped;
        psel && penable && pready && (paddr[1:0] != 2'b00 || paddr > 8'h14) |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("hole not refused");
    property p_start;
        psel && penable && pready && pwrite && paddr == 8'h00 && !busy |=> busy;
    endproperty
    a_start: assert property (p_start) else $error("control write did not start");
    property p_busy_len;
        $rose(busy) |-> ##[1:2] op_done;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("operation too long");
    property p_done_end;
        op_done |-> !busy && $past(busy);
    endproperty
    a_done_end: assert property (p_done_end) else $error("done out of place");
    // a taken skip costs exactly one dummy cycle
    property p_skip_frame;
        skip_next |-> busy ##1 (op_done && !skip_next && !busy);
    endproperty
    a_skip_frame: assert property (p_skip_frame) else $error("dummy cycle wrong");
    property p_skip_after_exec;
        $rose(skip_next) |-> $past(busy);
    endproperty
    a_skip_after_exec: assert property (p_skip_after_exec) else $error("skip early");
endmodule // xmem_unit_chk

// file: verilog/extended_memory_op_unit.v
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ns
// Overview of operation
// RQ1: operand address is absolute, no bank select
// RQ2: rotate right memory, bit0 to bit7, no flags
// RQ3: rotate right into work register, memory kept
// RQ4: rotate through borrow bit, only it changes
// RQ5: subtract with borrow: work minus mem minus notC
// RQ6: plain subtract: work minus memory, no borrow
// RQ7: borrow bit cleared negative, set otherwise
// RQ8: subtract updates exactly the six flags
// RQ9: taken skip adds one dummy cycle
// RQ10: decrement memory, skip when zero, no flags
// RQ11: decrement into work register, skip on zero
// RQ12: increment memory, skip when wraps to zero
// RQ13: increment into work register, skip on zero
// RQ14: fill byte with all ones, no flags
// RQ15: set selected bit only, no flags
// RQ16: skip when selected bit is one
// RQ17: skip when byte is nonzero, no write
// RQ18: swap nibbles to memory or work register
// RQ19: zero, overflow and low-nibble borrow conventions
`include "xmem_op_map.vh"

module extended_memory_op_unit #(
    parameter ADDR_W = 10
) (
    input  wire        clk_sys,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output wire        busy,
    output wire        skip_next,
    output wire        op_done
);
    // ------------------------------------------------------------------
    // states and storage
    // ------------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_EXEC  = 3'b010;
    localparam [2:0] ST_DUMMY = 3'b100;
    localparam       DEPTH    = 1 << ADDR_W;

    reg  [7:0]        mem [0:DEPTH-1];
    reg  [2:0]        state_q;
    reg  [2:0]        state_d;
    reg  [4:0]        op_q;
    reg  [2:0]        bit_q;
    reg  [ADDR_W-1:0] addr_q;
    reg  [7:0]        work_q;
    reg  [5:0]        flags_q;
    reg               skip_taken_q;
    reg               busy_q;
    reg               skip_next_q;
    reg               op_done_q;
    reg               pready_q;
    reg               pslverr_q;
    reg  [31:0]       prdata_q;

    reg  [7:0]        res_d;
    reg  [5:0]        flags_d;
    reg               mem_we;
    reg               work_we;
    reg               skip_d;
    reg  [31:0]       rd_data;

    wire [7:0]        opnd;
    wire              apb_wr;
    wire              apb_ack;
    wire              idle;
    wire              exec;
    wire              use_borrow;
    wire [7:0]        diff;
    wire              s_borrow;
    wire              s_nil;
    wire              s_half;
    wire              s_wrap;
    wire              s_aux;
    wire              s_chain;
    wire [7:0]        rot_plain;
    wire [7:0]        rot_borrow;
    wire              rot_bit_out;
    wire [7:0]        dec_val;
    wire [7:0]        inc_val;
    wire [7:0]        swap_val;
    wire [7:0]        set_val;
    wire              bit_is_one;
    wire              byte_nonzero;

    // ------------------------------------------------------------------
    // address decode helper
    // ------------------------------------------------------------------
    // misaligned or unknown offsets answer with an error and read zero
    function is_mapped;
        input [7:0] a;
        begin
            if (a == `OFF_CTRL) begin
                is_mapped = 1'b1;
            end else if (a == `OFF_ADDR) begin
                is_mapped = 1'b1;
            end else if (a == `OFF_WORK) begin
                is_mapped = 1'b1;
            end else if (a == `OFF_FLAGS) begin
                is_mapped = 1'b1;
            end else if (a == `OFF_STAT) begin
                is_mapped = 1'b1;
            end else if (a == `OFF_MDATA) begin
                is_mapped = 1'b1;
            end else begin
                is_mapped = 1'b0;
            end
        end
    endfunction

    assign idle    = (state_q == ST_IDLE);
    assign exec    = (state_q == ST_EXEC);
    assign apb_ack = psel & penable & pready_q;
    // writes land only in idle so the datapath never races software
    assign apb_wr  = apb_ack & pwrite & idle & is_mapped(paddr);
    // the full address reaches the array, no bank bits in front of it
    assign opnd    = mem[addr_q];                                   // RQ1

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign busy      = busy_q;
    assign skip_next = skip_next_q;
    assign op_done   = op_done_q;

    // ------------------------------------------------------------------
    // arithmetic helpers
    // ------------------------------------------------------------------
    assign use_borrow = (op_q == `OP_SBB_REG) | (op_q == `OP_SBB_MEM); // RQ5 RQ6

    sub_flag_calc u_sub (
        .minuend          (work_q),
        .subtrahend       (opnd),
        .use_borrow       (use_borrow),
        .borrow_in        (flags_q[`FLG_BORROW]),
        .chain_in         (flags_q[`FLG_CHAIN]),
        .diff             (diff),
        .borrow_out_bit   (s_borrow),
        .result_nil_flag  (s_nil),
        .half_borrow_bit  (s_half),
        .signed_wrap_flag (s_wrap),
        .aux_signed_flag  (s_aux),
        .chain_nil_flag   (s_chain)
    );

    xmem_misc_ops u_misc (
        .operand      (opnd),
        .bit_sel      (bit_q),
        .borrow_in    (flags_q[`FLG_BORROW]),
        .rot_plain    (rot_plain),
        .rot_borrow   (rot_borrow),
        .rot_bit_out  (rot_bit_out),
        .dec_val      (dec_val),
        .inc_val      (inc_val),
        .swap_val     (swap_val),
        .set_val      (set_val),
        .bit_is_one   (bit_is_one),
        .byte_nonzero (byte_nonzero)
    );

    // ------------------------------------------------------------------
    // operation select
    // ------------------------------------------------------------------
    // unknown codes fall through as a one-cycle no-op
    always @* begin
        res_d   = opnd;
        flags_d = flags_q;
        mem_we  = 1'b0;
        work_we = 1'b0;
        skip_d  = 1'b0;
        case (op_q)
            `OP_ROR_MEM: begin
                res_d  = rot_plain;                                 // RQ2
                mem_we = 1'b1;
            end
            `OP_ROR_REG: begin
                res_d   = rot_plain;                                // RQ3
                work_we = 1'b1;
            end
            `OP_RRB_MEM: begin
                res_d  = rot_borrow;                                // RQ4
                mem_we = 1'b1;
                flags_d[`FLG_BORROW] = rot_bit_out;
            end
            `OP_RRB_REG: begin
                res_d   = rot_borrow;                               // RQ4
                work_we = 1'b1;
                flags_d[`FLG_BORROW] = rot_bit_out;
            end
            `OP_SBB_REG, `OP_SUB_REG: begin
                res_d   = diff;                                     // RQ5 RQ6
                work_we = 1'b1;
                flags_d = {s_chain, s_aux, s_wrap, s_half, s_nil, s_borrow}; // RQ8
            end
            `OP_SBB_MEM, `OP_SUB_MEM: begin
                res_d   = diff;                                     // RQ5 RQ6
                mem_we  = 1'b1;
                flags_d = {s_chain, s_aux, s_wrap, s_half, s_nil, s_borrow}; // RQ8
            end
            `OP_DSK_MEM: begin
                res_d  = dec_val;                                   // RQ10
                mem_we = 1'b1;
                skip_d = (dec_val == `BYTE_ZERO);
            end
            `OP_DSK_REG: begin
                res_d   = dec_val;                                  // RQ11
                work_we = 1'b1;
                skip_d  = (dec_val == `BYTE_ZERO);
            end
            `OP_ISK_MEM: begin
                res_d  = inc_val;                                   // RQ12
                mem_we = 1'b1;
                skip_d = (inc_val == `BYTE_ZERO);
            end
            `OP_ISK_REG: begin
                res_d   = inc_val;                                  // RQ13
                work_we = 1'b1;
                skip_d  = (inc_val == `BYTE_ZERO);
            end
            `OP_FILL: begin
                res_d  = `BYTE_ONES;                                // RQ14
                mem_we = 1'b1;
            end
            `OP_SETBIT: begin
                res_d  = set_val;                                   // RQ15
                mem_we = 1'b1;
            end
            `OP_SKIP_BIT: begin
                skip_d = bit_is_one;                                // RQ16
            end
            `OP_SKIP_NZ: begin
                skip_d = byte_nonzero;                              // RQ17
            end
            `OP_SWAP_MEM: begin
                res_d  = swap_val;                                  // RQ18
                mem_we = 1'b1;
            end
            `OP_SWAP_REG: begin
                res_d   = swap_val;                                 // RQ18
                work_we = 1'b1;
            end
            default: begin
                res_d = opnd;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (apb_wr && paddr == `OFF_CTRL) begin
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                // a taken skip costs a second cycle for the refetch
                state_d = skip_d ? ST_DUMMY : ST_IDLE;              // RQ9
            end
            ST_DUMMY: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_q      <= ST_IDLE;
            busy_q       <= 1'b0;
            skip_next_q  <= 1'b0;
            op_done_q    <= 1'b0;
            skip_taken_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            busy_q      <= (state_d != ST_IDLE);
            skip_next_q <= (state_d == ST_DUMMY);                   // RQ9
            op_done_q   <= (state_d == ST_IDLE) & ~idle;
            if (exec) begin
                skip_taken_q <= skip_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // software-visible registers
    // ------------------------------------------------------------------
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            op_q    <= `OP_ROR_MEM;
            bit_q   <= 3'h0;
            addr_q  <= {ADDR_W{1'b0}};
            work_q  <= `WORK_RST;
            flags_q <= `FLAGS_RST;
        end else if (exec) begin
            // flags not named by the operation keep their old value
            flags_q <= flags_d;                                     // RQ8
            if (work_we) begin
                work_q <= res_d;                                    // RQ3 RQ11 RQ13
            end
        end else if (apb_wr) begin
            if (paddr == `OFF_CTRL) begin
                op_q  <= pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
                bit_q <= pwdata[`CTRL_BIT_MSB:`CTRL_BIT_LSB];
            end else if (paddr == `OFF_ADDR) begin
                addr_q <= pwdata[ADDR_W-1:0];                       // RQ1
            end else if (paddr == `OFF_WORK) begin
                work_q <= pwdata[7:0];
            end else if (paddr == `OFF_FLAGS) begin
                flags_q <= pwdata[5:0];
            end
        end
    end

    // single write port: datapath in exec, software otherwise
    always @(posedge clk_sys) begin
        if (exec && mem_we) begin
            mem[addr_q] <= res_d;                                   // RQ2 RQ10 RQ12
        end else if (apb_wr && paddr == `OFF_MDATA) begin
            mem[addr_q] <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // apb read path and handshake
    // ------------------------------------------------------------------
    always @* begin
        rd_data = 32'h0000_0000;
        if (paddr == `OFF_CTRL) begin
            rd_data = {21'h0, bit_q, 3'h0, op_q};
        end else if (paddr == `OFF_ADDR) begin
            rd_data[ADDR_W-1:0] = addr_q;
        end else if (paddr == `OFF_WORK) begin
            rd_data = {24'h0, work_q};
        end else if (paddr == `OFF_FLAGS) begin
            rd_data = {26'h0, flags_q};
        end else if (paddr == `OFF_STAT) begin
            rd_data[`STAT_BUSY] = busy_q;
            rd_data[`STAT_SKIP] = skip_taken_q;
        end else if (paddr == `OFF_MDATA) begin
            rd_data = {24'h0, opnd};
        end
    end

    // one wait state: pready rises in the second access cycle
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q <= psel & penable & ~pready_q;
            if (psel && penable && !pready_q) begin
                pslverr_q <= ~is_mapped(paddr);
                prdata_q  <= pwrite ? 32'h0000_0000 : rd_data;
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end
endmodule // extended_memory_op_unit

// file: verilog/sub_flag_calc.v
`timescale 1ns/1ns
`include "xmem_op_map.vh"
// ----------------------------------------------------------------------
// subtractor with full flag set, purely combinational
// ----------------------------------------------------------------------
module sub_flag_calc (
    input  wire [7:0] minuend,
    input  wire [7:0] subtrahend,
    input  wire       use_borrow,
    input  wire       borrow_in,
    input  wire       chain_in,
    output wire [7:0] diff,
    output wire       borrow_out_bit,
    output wire       result_nil_flag,
    output wire       half_borrow_bit,
    output wire       signed_wrap_flag,
    output wire       aux_signed_flag,
    output wire       chain_nil_flag
);
    wire       take;
    wire [8:0] wide;
    wire [4:0] low;

    // borrow_in is the stored carry: a set carry means no borrow pending
    assign take = use_borrow & ~borrow_in;                          // RQ5
    assign wide = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, take};
    assign low  = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, take};
    assign diff = wide[7:0];

    // carry reads as "no borrow": cleared on a negative true result
    assign borrow_out_bit   = ~wide[8];                             // RQ7
    assign result_nil_flag  = (wide[7:0] == `BYTE_ZERO);            // RQ19
    assign half_borrow_bit  = low[4];                               // RQ19
    assign signed_wrap_flag = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ wide[7]); // RQ19
    assign aux_signed_flag  = signed_wrap_flag ^ wide[7];
    // chained zero keeps a multi-byte compare honest across bytes
    assign chain_nil_flag   = use_borrow ? (result_nil_flag & chain_in) : result_nil_flag;
endmodule // sub_flag_calc

// file: verilog/xmem_misc_ops.v
`timescale 1ns/1ns
`include "xmem_op_map.vh"
// ----------------------------------------------------------------------
// rotate, step, swap and bit results of one operand byte
// ----------------------------------------------------------------------
module xmem_misc_ops (
    input  wire [7:0] operand,
    input  wire [2:0] bit_sel,
    input  wire       borrow_in,
    output wire [7:0] rot_plain,
    output wire [7:0] rot_borrow,
    output wire       rot_bit_out,
    output wire [7:0] dec_val,
    output wire [7:0] inc_val,
    output wire [7:0] swap_val,
    output wire [7:0] set_val,
    output wire       bit_is_one,
    output wire       byte_nonzero
);
    wire [7:0] mask;

    assign rot_plain    = {operand[0], operand[7:1]};               // RQ2 RQ3
    assign rot_borrow   = {borrow_in, operand[7:1]};                // RQ4
    assign rot_bit_out  = operand[0];                               // RQ4
    assign dec_val      = operand - `BYTE_ONE;                      // RQ10 RQ11
    assign inc_val      = operand + `BYTE_ONE;                      // RQ12 RQ13
    assign swap_val     = {operand[3:0], operand[7:4]};             // RQ18
    assign mask         = `BYTE_ONE << bit_sel;
    assign set_val      = operand | mask;                           // RQ15
    assign bit_is_one   = |(operand & mask);                        // RQ16
    assign byte_nonzero = (operand != `BYTE_ZERO);                  // RQ17
endmodule // xmem_misc_ops

// file: verilog/xmem_op_map.vh
`ifndef XMEM_OP_MAP_VH
`define XMEM_OP_MAP_VH

// ----------------------------------------------------------------------
// register byte offsets on the apb window
// ----------------------------------------------------------------------
`define OFF_CTRL        8'h00
`define OFF_ADDR        8'h04
`define OFF_WORK        8'h08
`define OFF_FLAGS       8'h0c
`define OFF_STAT        8'h10
`define OFF_MDATA       8'h14

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CTRL_OP_MSB     4
`define CTRL_OP_LSB     0
`define CTRL_BIT_MSB    10
`define CTRL_BIT_LSB    8
`define FLG_BORROW      0
`define FLG_NIL         1
`define FLG_HALF        2
`define FLG_WRAP        3
`define FLG_AUX         4
`define FLG_CHAIN       5
`define STAT_BUSY       0
`define STAT_SKIP       1

// ----------------------------------------------------------------------
// reset values and fixed data
// ----------------------------------------------------------------------
`define WORK_RST        8'h00
`define FLAGS_RST       6'h00
`define BYTE_ZERO       8'h00
`define BYTE_ONES       8'hff
`define BYTE_ONE        8'h01

// ----------------------------------------------------------------------
// operation codes written to the control register
// ----------------------------------------------------------------------
`define OP_ROR_MEM      5'h00
`define OP_ROR_REG      5'h01
`define OP_RRB_MEM      5'h02
`define OP_RRB_REG      5'h03
`define OP_SBB_REG      5'h04
`define OP_SBB_MEM      5'h05
`define OP_SUB_REG      5'h06
`define OP_SUB_MEM      5'h07
`define OP_DSK_MEM      5'h08
`define OP_DSK_REG      5'h09
`define OP_ISK_MEM      5'h0a
`define OP_ISK_REG      5'h0b
`define OP_FILL         5'h0c
`define OP_SETBIT       5'h0d
`define OP_SKIP_BIT     5'h0e
`define OP_SKIP_NZ      5'h0f
`define OP_SWAP_MEM     5'h10
`define OP_SWAP_REG     5'h11

`endif
